// >>> verif/core_model.sv
`timescale 1ns/1ps

// Core side: ends each interrupt cycle after a set delay
module core_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Cycle handshake
    input wire logic core_irq_req,
    input wire logic [3:0] delay,
    output logic cycle_done
);
    logic [3:0] cnt;
    logic sent;

    // One done pulse per cycle; the flag blocks a second pulse while req falls
    always_ff @(posedge clk_sys) begin
        if (!nrst || !core_irq_req) begin
            cnt <= 4'h0;
            sent <= 1'b0;
            cycle_done <= 1'b0;
        end else if (!sent && cnt == delay) begin
            sent <= 1'b1;
            cycle_done <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
            cycle_done <= 1'b0;
        end
    end
endmodule

// >>> verif/interrupt_priority_request_unit_asserts.sv
`timescale 1ns/1ps

// Port-level checks of the request unit
module interrupt_priority_request_unit_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Core side
    input wire logic enable_interrupts_instruction,
    input wire logic cycle_done,
    input wire logic core_irq_req,
    input wire logic [2:0] core_irq_id,
    input wire logic [7:0] core_vector_addr,
    input wire logic irq_out
);
    logic unlocked;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Remembers the first enable since reset
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            unlocked <= 1'b0;
        end else if (enable_interrupts_instruction) begin
            unlocked <= 1'b1;
        end
    end

    sequence in_cycle;
        core_irq_req && !cycle_done;
    endsequence

    sequence done_seen;
        core_irq_req && cycle_done;
    endsequence

    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    vector_id_a: assert property (core_irq_req |-> core_vector_addr == {4'h0, core_irq_id, 1'b0})
        else $error("vector does not match winner");
    req_hold_a: assert property (in_cycle |=> core_irq_req && $stable(core_irq_id))
        else $error("cycle changed before done");
    req_drop_a: assert property (done_seen |=> !core_irq_req)
        else $error("request held after done");
    locked_quiet_a: assert property (!unlocked |-> !core_irq_req)
        else $error("grant before enable");
    config_read_a: assert property (reg_rd && reg_addr == irq_unit_pkg::off_priority_config |=> reg_rdata == 8'h00)
        else $error("config read not zero");
    one_winner_a: assert property (core_irq_req |-> core_irq_id < 3'h6)
        else $error("winner out of range");
    reset_quiet_a: assert property ($rose(nrst) |-> !core_irq_req && !irq_out)
        else $error("outputs active after reset");
endmodule

bind interrupt_priority_request_unit interrupt_priority_request_unit_asserts u_asserts (
    .clk_sys, .nrst, .reg_addr, .reg_rd, .reg_rdata, .enable_interrupts_instruction,
    .cycle_done, .core_irq_req, .core_irq_id, .core_vector_addr, .irq_out
);

// >>> verif/interrupt_priority_request_unit_test.sv
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module interrupt_priority_request_unit_test;
    typedef struct packed {logic [7:0] cfg; logic [3:0] dly; logic [17:0] order;} row_t;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ev = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0, ei = 1'b0, rx_en = 1'b0, pin_a = 1'b0, pin_b = 1'b0;
    logic [3:0] core_delay = 4'h0;
    logic [7:0] reg_rdata, core_vector_addr;
    logic [2:0] core_irq_id;
    logic [1:0] mode;
    logic core_irq_req, cycle_done, irq_out;
    int n_fail = 0, comparisons = 0;
    // All six pending: config, core delay, service order first to last
    row_t rows [6] = '{
        '{8'h01, 4'h0, {3'h1, 3'h4, 3'h5, 3'h3, 3'h2, 3'h0}},
        '{8'h28, 4'h9, {3'h3, 3'h5, 3'h2, 3'h0, 3'h1, 3'h4}},
        '{8'h0D, 4'h0, {3'h5, 3'h3, 3'h1, 3'h4, 3'h0, 3'h2}},
        '{8'h12, 4'h9, {3'h2, 3'h0, 3'h4, 3'h1, 3'h5, 3'h3}},
        '{8'h37, 4'h0, {3'h4, 3'h1, 3'h0, 3'h2, 3'h3, 3'h5}},
        '{8'h18, 4'h9, {3'h2, 3'h0, 3'h5, 3'h3, 3'h1, 3'h4}}};
    // Flag expected from each source: three levels, three on flag 1, rx, falling pin
    logic [7:0] src_flag [8] = '{8'h20, 8'h10, 8'h08, 8'h02, 8'h02, 8'h02, 8'h01, 8'h02};

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    interrupt_priority_request_unit u_interrupt_priority_request_unit (
        .clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .low_voltage_event(ev[0]), .carrier_timer_event(ev[1]), .envelope_timer_event(ev[2]),
        .port_pin_edge_a(pin_a), .port_pin_edge_b(pin_b), .port_pin_falling_c(ev[7]),
        .stop_recovery_event(ev[3]), .serial_tx_event(ev[4]), .baud_tick_event(ev[5]),
        .serial_rx_event(ev[6]), .serial_rx_enabled(rx_en), .enable_interrupts_instruction(ei),
        .cycle_done, .core_irq_req, .core_irq_id, .core_vector_addr, .irq_out
    );

    core_model u_core_model (.clk_sys, .nrst, .core_irq_req, .delay(core_delay), .cycle_done);

    // Bus cycles: one-cycle strobes, read data taken just after the answer edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, exp, reg_rdata)
    endtask

    task automatic wfl(input logic [7:0] d);
        wr(irq_unit_pkg::off_request_flags, d);
    endtask

    task automatic rfl(input logic [7:0] exp, input string nm);
        rd(irq_unit_pkg::off_request_flags, exp, nm);
    endtask

    task automatic wm(input logic [7:0] d);
        wr(irq_unit_pkg::off_enable_mask, d);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Bounded wait for the cycle request to reach a level
    task automatic wait_req(input logic lvl);
        int n;
        n = 0;
        while (core_irq_req !== lvl && n < 40) begin
            tick(1);
            n++;
        end
        `CHK("core request", lvl, core_irq_req)
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Run takes well under a thousand cycles; this 10000-cycle margin only cuts a hang
    initial begin
        #40000;
        n_fail++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        ei <= 1'b1;
        @(posedge clk_sys);
        ei <= 1'b0;
        foreach (rows[i]) begin
            core_delay <= rows[i].dly;
            wm(8'h00);
            wr(irq_unit_pkg::off_priority_config, rows[i].cfg);
            wfl(8'h3F);
            wm(8'hBF);
            for (int k = 5; k >= 0; k--) begin
                wait_req(1'b1);
                `CHK("winner", rows[i].order[3*k +: 3], core_irq_id)
                `CHK("vector", {4'h0, rows[i].order[3*k +: 3], 1'b0}, core_vector_addr)
                wait_req(1'b0);
            end
            rfl(8'h00, "flags serviced");
            $display("done: order row %0d", i);
        end
        // Software set and clear, then gating by each enable
        wm(8'h00);
        wfl(8'h15);
        rfl(8'h15, "flags set");
        wfl(8'h00);
        rfl(8'h00, "flags cleared");
        wr(irq_unit_pkg::off_status, 8'h03);
        wr(irq_unit_pkg::off_status_mask, 8'h01);
        wfl(8'h08);
        wm(8'h08);
        tick(4);
        `CHK("grant, master off", 1'b0, core_irq_req)
        `CHK("irq out, no grant", 1'b0, irq_out)
        wm(8'h80);
        tick(4);
        `CHK("grant, source off", 1'b0, core_irq_req)
        wm(8'h88);
        wait_req(1'b1);
        `CHK("grant id", 3'h3, core_irq_id)
        wait_req(1'b0);
        `CHK("irq out", 1'b1, irq_out)
        wr(irq_unit_pkg::off_status, 8'h01);
        tick(2);
        `CHK("irq cleared", 1'b0, irq_out)
        $display("done: set, clear and gating");
        // Edge selection: every mode, both directions on both pins
        wm(8'h00);
        for (int m = 0; m < 4; m++) begin
            mode = m[1:0];
            wfl({mode, 6'h00});
            {pin_a, pin_b} <= 2'b11;
            tick(3);
            rfl({mode, 3'h0, mode[1], 1'b0, mode[0]}, "rising edges");
            wfl({mode, 6'h00});
            {pin_a, pin_b} <= 2'b00;
            tick(3);
            rfl({mode, 3'h0, ~mode[1] | mode[0], 1'b0, ~mode[0] | mode[1]}, "falling edges");
        end
        $display("done: edge modes");
        // Each hardware source lands on its mapped flag; four share flag 1
        rx_en <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            wfl(8'h00);
            ev <= 8'h01 << s;
            @(posedge clk_sys);
            ev <= 8'h00;
            tick(3);
            rfl(src_flag[s], "source flag");
        end
        $display("done: sources");
        rd(8'h10, 8'h00, "unmapped read");
        rd(irq_unit_pkg::off_priority_config, 8'h00, "config read");
        wr(irq_unit_pkg::off_priority_config, 8'h00);
        rd(irq_unit_pkg::off_status, 8'h02, "reserved code flagged");
        wr(irq_unit_pkg::off_status, 8'h02);
        rd(irq_unit_pkg::off_status, 8'h00, "reserved flag cleared");
        // Reset in mid-run: values back to reset, register locked again
        wfl(8'h21);
        nrst <= 1'b0;
        tick(5);
        @(posedge clk_sys);
        nrst <= 1'b1;
        rfl(8'h00, "flags after reset");
        rd(irq_unit_pkg::off_enable_mask, 8'h00, "mask after reset");
        wfl(8'h3F);
        ev <= 8'h01;
        @(posedge clk_sys);
        ev <= 8'h00;
        tick(3);
        rfl(8'h00, "flags locked");
        $display("done: reset and lock");
        summarize();
    end
endmodule

// >>> verilog/edge_detect.sv
`timescale 1ns/1ps

// Edge detector with selectable rising, falling or both
module edge_detect (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Pin and selection
    input wire logic pin,
    input wire logic sel_rise,
    input wire logic sel_fall,
    // Detected event
    output logic hit
);

    logic pin_prev;
    wire rise = pin & ~pin_prev;
    wire fall = ~pin & pin_prev;

    // ------------------------------------------------------------
    // Previous sample and event pulse
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_prev <= pin; // Start from the pin's level, so no false edge follows reset
            hit <= 1'b0;
        end else begin
            pin_prev <= pin;
            hit <= (rise & sel_rise) | (fall & sel_fall);
        end
    end

endmodule

// >>> verilog/interrupt_priority_request_unit.sv
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

module interrupt_priority_request_unit (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Request sources
    input wire logic low_voltage_event,
    input wire logic carrier_timer_event,
    input wire logic envelope_timer_event,
    input wire logic port_pin_edge_a,
    input wire logic port_pin_edge_b,
    input wire logic port_pin_falling_c,
    input wire logic stop_recovery_event,
    input wire logic serial_tx_event,
    input wire logic baud_tick_event,
    input wire logic serial_rx_event,
    input wire logic serial_rx_enabled,
    // Core interrupt sequencing
    input wire logic enable_interrupts_instruction,
    input wire logic cycle_done,
    output logic core_irq_req,
    output logic [2:0] core_irq_id,
    output logic [7:0] core_vector_addr,
    output logic irq_out
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] priority_config;
    logic [7:0] request_flags;
    logic [7:0] interrupt_enable_mask;
    logic [1:0] status;
    logic [1:0] status_mask;
    logic unlocked;
    irq_unit_pkg::arb_state_t state;
    logic [2:0] next_win_id;

    // Choose the higher of a pair: first outranks second
    function automatic logic [3:0] pick_pair(input logic [5:0] req, input logic [2:0] first,
                                             input logic [2:0] second);
        if (req[first]) begin
            pick_pair = {1'b1, first};
        end else if (req[second]) begin
            pick_pair = {1'b1, second};
        end else begin
            pick_pair = 4'h0;
        end
    endfunction

    // Winner of three group results taken in the given order
    function automatic logic [2:0] pick_group(input logic [3:0] first, input logic [3:0] second,
                                              input logic [3:0] third);
        if (first[3]) begin
            pick_group = first[2:0];
        end else if (second[3]) begin
            pick_group = second[2:0];
        end else begin
            pick_group = third[2:0];
        end
    endfunction

    // Group order code sits in scattered bits {4, 3, 0}
    function automatic logic [2:0] group_code_of(input logic [7:0] cfg);
        group_code_of = {cfg[4], cfg[3], cfg[0]};
    endfunction

    // Codes 000 and 111 carry no defined group order
    function automatic logic code_reserved(input logic [2:0] code);
        code_reserved = (code == 3'h0) || (code == 3'h7);
    endfunction

    // ------------------------------------------------------------
    // Edge detectors for the two selectable pins and the falling-only pin c
    // ------------------------------------------------------------
    wire [1:0] edge_sel = request_flags[irq_unit_pkg::pos_edge_hi:irq_unit_pkg::pos_edge_lo];
    // Mode 11 arms both edges on both pins
    wire a_rise = edge_sel[1];
    wire a_fall = ~edge_sel[1] | edge_sel[0];
    wire b_rise = edge_sel[0];
    wire b_fall = ~edge_sel[0] | edge_sel[1];
    logic hit_a;
    logic hit_b;
    logic hit_c;

    edge_detect u_edge_a (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin(port_pin_edge_a),
        .sel_rise(a_rise),
        .sel_fall(a_fall),
        .hit(hit_a)
    );

    edge_detect u_edge_b (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin(port_pin_edge_b),
        .sel_rise(b_rise),
        .sel_fall(b_fall),
        .hit(hit_b)
    );

    edge_detect u_edge_c (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .pin(port_pin_falling_c),
        .sel_rise(1'b0),
        .sel_fall(1'b1),
        .hit(hit_c)
    );

    // ------------------------------------------------------------
    // Source wiring into the six flags
    // ------------------------------------------------------------
    // Serial receive replaces the pin b source while enabled
    wire src0 = serial_rx_enabled ? serial_rx_event : hit_b;
    wire src1 = hit_c | stop_recovery_event | serial_tx_event | baud_tick_event;
    wire [5:0] hw_set = {low_voltage_event, carrier_timer_event, envelope_timer_event,
                         hit_a, src1, src0};

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    wire wr_cfg = reg_wr & (reg_addr == irq_unit_pkg::off_priority_config);
    wire wr_req = reg_wr & (reg_addr == irq_unit_pkg::off_request_flags);
    wire wr_mask = reg_wr & (reg_addr == irq_unit_pkg::off_enable_mask);
    wire wr_stat = reg_wr & (reg_addr == irq_unit_pkg::off_status);
    wire wr_smask = reg_wr & (reg_addr == irq_unit_pkg::off_status_mask);
    wire [7:0] rd_mux =
        (reg_addr == irq_unit_pkg::off_request_flags) ? request_flags :
        (reg_addr == irq_unit_pkg::off_enable_mask) ? {interrupt_enable_mask[7], 1'b0,
                                                       interrupt_enable_mask[5:0]} :
        (reg_addr == irq_unit_pkg::off_status) ? {6'h00, status} :
        (reg_addr == irq_unit_pkg::off_status_mask) ? {6'h00, status_mask} :
        8'h00; // Priority config is write only; unmapped reads zero

    // ------------------------------------------------------------
    // Arbitration among pending and enabled requests
    // ------------------------------------------------------------
    // Master enable gates every source at once
    wire master_on = interrupt_enable_mask[irq_unit_pkg::pos_master_enable];
    wire [5:0] eligible = request_flags[5:0] & interrupt_enable_mask[5:0] & {6{master_on}};
    wire [3:0] win_a = priority_config[irq_unit_pkg::pos_grp_a_order] ?
                       pick_pair(eligible, 3'd3, 3'd5) : pick_pair(eligible, 3'd5, 3'd3);
    wire [3:0] win_b = priority_config[irq_unit_pkg::pos_grp_b_order] ?
                       pick_pair(eligible, 3'd0, 3'd2) : pick_pair(eligible, 3'd2, 3'd0);
    wire [3:0] win_c = priority_config[irq_unit_pkg::pos_grp_c_order] ?
                       pick_pair(eligible, 3'd4, 3'd1) : pick_pair(eligible, 3'd1, 3'd4);
    wire [2:0] grp_code = group_code_of(priority_config);
    // Flag a reserved code as it is written, not once it already stands
    wire wr_reserved = wr_cfg & code_reserved(group_code_of(reg_wdata));

    // Group order; reserved codes fall back to A>B>C so a winner still exists
    always_comb begin
        next_win_id = 3'h0;
        case (grp_code)
            irq_unit_pkg::grp_c_a_b: begin
                next_win_id = pick_group(win_c, win_a, win_b);
            end
            irq_unit_pkg::grp_a_b_c: begin
                next_win_id = pick_group(win_a, win_b, win_c);
            end
            irq_unit_pkg::grp_a_c_b: begin
                next_win_id = pick_group(win_a, win_c, win_b);
            end
            irq_unit_pkg::grp_b_c_a: begin
                next_win_id = pick_group(win_b, win_c, win_a);
            end
            irq_unit_pkg::grp_c_b_a: begin
                next_win_id = pick_group(win_c, win_b, win_a);
            end
            irq_unit_pkg::grp_b_a_c: begin
                next_win_id = pick_group(win_b, win_a, win_c);
            end
            default: begin
                next_win_id = pick_group(win_a, win_b, win_c);
            end
        endcase
    end

    // A grant needs an idle arbiter, so one cycle stays free after each done
    wire any_eligible = |eligible;
    wire grant = (state == irq_unit_pkg::arb_idle) & any_eligible & unlocked;
    // One-hot clear of the serviced flag
    wire [5:0] svc_clear = grant ? (6'h01 << next_win_id) : 6'h00;

    // ------------------------------------------------------------
    // Unlock after the first enable instruction
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            unlocked <= 1'b0;
        end else if (enable_interrupts_instruction) begin
            unlocked <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Configuration and mask registers
    // ------------------------------------------------------------
    // Config bits 7:6 are reserved and kept at zero
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            priority_config <= irq_unit_pkg::rst_priority_config;
        end else if (wr_cfg) begin
            priority_config <= {2'b00, reg_wdata[5:0]};
        end
    end

    // Enable instruction sets the master bit unless software writes the mask that cycle
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            interrupt_enable_mask <= irq_unit_pkg::rst_enable_mask;
        end else if (wr_mask) begin
            interrupt_enable_mask <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
        end else if (enable_interrupts_instruction) begin
            interrupt_enable_mask[irq_unit_pkg::pos_master_enable] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Request flags: write, hardware set, service clear
    // ------------------------------------------------------------
    // Hardware sets win over a software clear in the same cycle
    // The serviced flag drops on the write path too; only a hardware set of that source in the grant cycle leaves it set
    wire [5:0] pend_after_wr = (reg_wdata[5:0] & ~svc_clear) | hw_set;
    wire [5:0] pend_after_hw = (request_flags[5:0] & ~svc_clear) | hw_set;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            request_flags <= irq_unit_pkg::rst_request_flags;
        end else if (unlocked) begin
            if (wr_req) begin
                request_flags <= {reg_wdata[7:6], pend_after_wr};
            end else begin
                request_flags[5:0] <= pend_after_hw;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt cycle handshake to the core
    // ------------------------------------------------------------
    // Further grants wait until the core reports the cycle done
    // Vector output is the low byte location; the high byte follows at the next one
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state <= irq_unit_pkg::arb_idle;
            core_irq_req <= 1'b0;
            core_irq_id <= 3'h0;
            core_vector_addr <= 8'h00;
        end else begin
            case (state)
                irq_unit_pkg::arb_idle: begin
                    if (grant) begin
                        state <= irq_unit_pkg::arb_wait_ack;
                        core_irq_req <= 1'b1;
                        core_irq_id <= next_win_id;
                        core_vector_addr <= {4'h0, next_win_id, 1'b0};
                    end
                end
                irq_unit_pkg::arb_wait_ack: begin
                    if (cycle_done) begin
                        state <= irq_unit_pkg::arb_idle;
                        core_irq_req <= 1'b0;
                    end
                end
                default: begin
                    state <= irq_unit_pkg::arb_idle;
                    core_irq_req <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Unit status, mask and interrupt line
    // ------------------------------------------------------------
    // Events set sticky bits; a set beats a write-one clear
    wire [1:0] stat_set = {wr_reserved, grant};
    wire [1:0] stat_clr = wr_stat ? reg_wdata[1:0] : 2'b00;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            status <= irq_unit_pkg::rst_status;
        end else begin
            status <= (status & ~stat_clr) | stat_set;
        end
    end

    // Status mask has the same layout as the status bits
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            status_mask <= irq_unit_pkg::rst_status;
        end else if (wr_smask) begin
            status_mask <= reg_wdata[1:0];
        end
    end

    // Level line, one cycle behind the status bits so it leaves a flip-flop
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status & status_mask);
        end
    end

    // Read data stand one cycle, then return to zero
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

endmodule

// >>> verilog/irq_unit_pkg.sv
package irq_unit_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] off_priority_config = 8'hF9;
    localparam logic [7:0] off_request_flags = 8'hFA;
    localparam logic [7:0] off_enable_mask = 8'hFB;
    localparam logic [7:0] off_status = 8'hFC;
    localparam logic [7:0] off_status_mask = 8'hFD;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int num_requests = 6;
    localparam int pos_master_enable = 7;
    localparam int pos_grp_a_order = 5;
    localparam int pos_grp_b_order = 2;
    localparam int pos_grp_c_order = 1;
    localparam int pos_edge_hi = 7;
    localparam int pos_edge_lo = 6;
    localparam logic [7:0] rst_request_flags = 8'h00;
    localparam logic [7:0] rst_priority_config = 8'h00;
    localparam logic [7:0] rst_enable_mask = 8'h00;
    localparam logic [1:0] rst_status = 2'h0;

    // Status bits of the unit's own event register
    localparam int stat_grant = 0;
    localparam int stat_reserved_code = 1;

    // ------------------------------------------------------------
    // Group ordering codes, {cfg[4], cfg[3], cfg[0]}
    // ------------------------------------------------------------
    localparam logic [2:0] grp_c_a_b = 3'h1;
    localparam logic [2:0] grp_a_b_c = 3'h2;
    localparam logic [2:0] grp_a_c_b = 3'h3;
    localparam logic [2:0] grp_b_c_a = 3'h4;
    localparam logic [2:0] grp_c_b_a = 3'h5;
    localparam logic [2:0] grp_b_a_c = 3'h6;

    // Arbiter states
    typedef enum logic [1:0] {
        arb_idle,
        arb_wait_ack
    } arb_state_t;

endpackage
